// ===== logic/tdb_distribution_board.sv
// Purpose: Command relay, trigger fan-out and busy merge of the board
// Assumes: Link clock and all pins but the trigger word path asynchronous to clk (200 MHz)
// Notes: Trigger word path is same-clock; it is only buffered, not decoded

// Overview of operation
// - Sample command line once per link clock
// - Idle after more than four ones
// - Zero start bit, four bits LSB first
// - Closing one returns line to idle
// - Align command line before sampling, then decode
// - Re-encode one command stream for fan-out
// - Decode commands into local one-hot actions
// - Pass trigger words through, undecoded
// - Pair one words/status, two clock, three commands
// - Fourth pair looped back for latency
// - Trigger from rear pair or backplane line
// - OR of front-end busy bits
// - Missing trigger acknowledges assert busy
// - Readout acks versus blocks give occupancy
// - High occupancy asserts busy, blocks triggers
// - Merged busy goes upstream
// - Trigger word every 16 ns, status back
module tdb_distribution_board #(
    parameter int NCH = tdb_pkg::NUM_CH,
    parameter logic [tdb_pkg::CNT_W-1:0] ACK_SLACK = tdb_pkg::ACK_SLACK,
    parameter logic [tdb_pkg::CNT_W-1:0] OCC_HIGH = tdb_pkg::OCC_HIGH,
    parameter logic [tdb_pkg::CNT_W-1:0] BLK_PER_TRIG = tdb_pkg::BLK_PER_TRIG
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk, // Command link clock, sampled
    input wire logic cmd_line_in, // Serial commands from supervisor
    output logic cmd_line_out, // Re-encoded commands to fan-out
    output tdb_pkg::tdb_cmd_type cmd_out, // Decoded command strobe
    output logic [tdb_pkg::ACT_W-1:0] local_action, // One-hot pulses
    input wire logic [tdb_pkg::WORD_W-1:0] trig_word_in,
    input wire logic trig_word_in_valid,
    output logic trig_word_in_ready,
    output logic [tdb_pkg::WORD_W-1:0] trig_word_out,
    output logic trig_word_out_valid,
    input wire logic trig_word_out_ready,
    input wire logic trig_rear_in, // Twisted-pair trigger pulse
    input wire logic trig_bp_in, // Backplane trigger line
    input wire logic trig_sel_bp, // High selects backplane source
    output logic trig_out, // Forwarded trigger pulse
    input wire tdb_pkg::tdb_fe_status_type [NCH-1:0] fe_status,
    input wire logic [NCH-1:0] loop_rx, // Fourth pair receive
    output logic [NCH-1:0] loop_tx, // Fourth pair transmit
    output logic busy_out // Merged busy upstream
);
    // ==========================================================
    // Input synchronisers
    // ==========================================================
    logic [1:0] lclk_sync_reg; // Link clock pair
    logic lclk_prev_reg; // For edge finding
    logic [1:0] cmd_sync_reg; // Command line pair
    logic [2:0] trg_sync0_reg; // First stage: rear, bp, select
    logic [2:0] trg_sync1_reg; // Second stage
    logic trg_prev_reg; // Selected source, last cycle
    logic link_edge; // One-cycle pulse per link period
    logic trg_sel; // Selected trigger level
    logic trg_rise; // New trigger pulse

    // Two flops on every asynchronous pin
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lclk_sync_reg <= 2'h0;
            lclk_prev_reg <= 1'b0;
            cmd_sync_reg <= 2'h3;
            trg_sync0_reg <= 3'h0;
            trg_sync1_reg <= 3'h0;
            trg_prev_reg <= 1'b0;
        end else begin
            lclk_sync_reg <= {lclk_sync_reg[0], link_clk};
            lclk_prev_reg <= lclk_sync_reg[1];
            cmd_sync_reg <= {cmd_sync_reg[0], cmd_line_in};
            trg_sync0_reg <= {trig_sel_bp, trig_bp_in, trig_rear_in};
            trg_sync1_reg <= trg_sync0_reg;
            trg_prev_reg <= trg_sel;
        end
    end

    // Rising link edge; the line is read only here
    assign link_edge = lclk_sync_reg[1] & ~lclk_prev_reg;

    // Either trigger source, chosen by the select pin
    assign trg_sel = trg_sync1_reg[2] ? trg_sync1_reg[1] : trg_sync1_reg[0];
    assign trg_rise = trg_sel & ~trg_prev_reg;

    // ==========================================================
    // Command decoder
    // ==========================================================
    tdb_pkg::tdb_dec_state_type dec_state_reg;
    logic [2:0] ones_reg; // Saturating count of idle ones
    logic [2:0] bit_cnt_reg; // Code bits taken so far
    logic [tdb_pkg::CMD_W-1:0] code_reg; // Code shift register
    tdb_pkg::tdb_cmd_type cmd_reg; // Decoded command
    logic cmd_bit; // Aligned command sample

    assign cmd_bit = cmd_sync_reg[1];

    // Frame decoder, advances once per link edge
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dec_state_reg <= tdb_pkg::DEC_WAIT_IDLE;
            ones_reg <= 3'h0;
            bit_cnt_reg <= 3'h0;
            code_reg <= 4'h0;
            cmd_reg <= '0;
        end else begin
            cmd_reg.valid <= 1'b0;
            if (link_edge) begin
                case (dec_state_reg)
                    // Count ones until the line is idle
                    tdb_pkg::DEC_WAIT_IDLE: begin
                        if (cmd_bit != tdb_pkg::LINE_IDLE) begin
                            ones_reg <= 3'h0; // A zero breaks the run
                        end else if (ones_reg == tdb_pkg::IDLE_ONES - 3'h1) begin
                            dec_state_reg <= tdb_pkg::DEC_ARMED;
                        end else begin
                            ones_reg <= ones_reg + 3'h1;
                        end
                    end
                    // Idle: a single zero opens a frame
                    tdb_pkg::DEC_ARMED: begin
                        if (cmd_bit == tdb_pkg::START_BIT) begin
                            dec_state_reg <= tdb_pkg::DEC_DATA;
                            bit_cnt_reg <= 3'h0;
                        end
                    end
                    // Four code bits, first one is the LSB
                    tdb_pkg::DEC_DATA: begin
                        code_reg <= {cmd_bit, code_reg[3:1]};
                        bit_cnt_reg <= bit_cnt_reg + 3'h1;
                        if (bit_cnt_reg == tdb_pkg::CMD_BITS - 3'h1) begin
                            cmd_reg.valid <= 1'b1;
                            cmd_reg.code <= {cmd_bit, code_reg[3:1]};
                            // Re-arm only after a fresh idle run
                            dec_state_reg <= tdb_pkg::DEC_WAIT_IDLE;
                            ones_reg <= 3'h0;
                        end
                    end
                    default: begin
                        dec_state_reg <= tdb_pkg::DEC_WAIT_IDLE;
                        ones_reg <= 3'h0;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Local actions and command output
    // ==========================================================
    logic [tdb_pkg::ACT_W-1:0] action_reg; // One-hot action pulses

    // Every code maps to one action line for the board itself
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            action_reg <= '0;
        end else begin
            action_reg <= '0;
            if (cmd_reg.valid) begin
                action_reg[cmd_reg.code] <= 1'b1;
            end
        end
    end

    assign cmd_out = cmd_reg;
    assign local_action = action_reg;

    // ==========================================================
    // Command re-encoder
    // ==========================================================
    logic [9:0] enc_sreg_reg; // Bits still to send, LSB first
    logic [3:0] enc_cnt_reg; // Bits left in frame
    logic enc_line_reg; // Driven line level
    logic enc_load; // Decoded frame taken

    // A new frame is taken only with the last guard bit sent.
    // Input frames are at least as long, so none is dropped.
    assign enc_load = cmd_reg.valid && (enc_cnt_reg == 4'h0);

    // Same framing downstream: start, code, stop, idle ones
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            enc_sreg_reg <= '1;
            enc_cnt_reg <= 4'h0;
            enc_line_reg <= tdb_pkg::LINE_IDLE;
        end else begin
            if (enc_load) begin
                enc_sreg_reg <= tdb_pkg::ENC_GUARD | {5'h00, cmd_reg.code,
                    tdb_pkg::START_BIT};
                enc_cnt_reg <= tdb_pkg::ENC_LEN;
            end else if (link_edge && enc_cnt_reg != 4'h0) begin
                enc_line_reg <= enc_sreg_reg[0];
                enc_sreg_reg <= {1'b1, enc_sreg_reg[9:1]};
                enc_cnt_reg <= enc_cnt_reg - 4'h1;
            end
        end
    end

    // Single stream feeds the external fan-out to all links
    assign cmd_line_out = enc_line_reg;

    // ==========================================================
    // Trigger word buffer, two entries
    // ==========================================================
    logic [tdb_pkg::WORD_W-1:0] head_reg; // Word offered downstream
    logic [tdb_pkg::WORD_W-1:0] tail_reg; // Word held on a stall
    logic head_v_reg;
    logic tail_v_reg;
    logic in_rdy_reg;
    logic push;
    logic pop;

    assign push = trig_word_in_valid & in_rdy_reg;
    assign pop = head_v_reg & trig_word_out_ready;

    // Words pass untouched; a receiver stall fills the tail
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            head_reg <= '0;
            tail_reg <= '0;
            head_v_reg <= 1'b0;
            tail_v_reg <= 1'b0;
            in_rdy_reg <= 1'b1;
        end else begin
            case ({push, pop})
                2'b10: begin
                    if (!head_v_reg) begin
                        head_reg <= trig_word_in;
                        head_v_reg <= 1'b1;
                    end else begin
                        tail_reg <= trig_word_in;
                        tail_v_reg <= 1'b1;
                        in_rdy_reg <= 1'b0; // Full: stall source
                    end
                end
                2'b01: begin
                    if (tail_v_reg) begin
                        head_reg <= tail_reg;
                        tail_v_reg <= 1'b0;
                        in_rdy_reg <= 1'b1;
                    end else begin
                        head_v_reg <= 1'b0;
                    end
                end
                2'b11: begin
                    if (tail_v_reg) begin
                        head_reg <= tail_reg;
                        tail_reg <= trig_word_in;
                    end else begin
                        head_reg <= trig_word_in;
                    end
                end
                default: begin
                    head_v_reg <= head_v_reg;
                end
            endcase
        end
    end

    // Pair one: words down here, status back on fe_status
    assign trig_word_out = head_reg;
    assign trig_word_out_valid = head_v_reg;
    assign trig_word_in_ready = in_rdy_reg;

    // ==========================================================
    // Trigger forwarding
    // ==========================================================
    logic trig_out_reg; // Pulse sent to all links
    logic busy_reg; // Merged busy

    // Busy withholds new triggers from the front ends
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            trig_out_reg <= 1'b0;
        end else begin
            trig_out_reg <= trg_rise & ~busy_reg;
        end
    end

    assign trig_out = trig_out_reg;

    // ==========================================================
    // Per-channel status tracking
    // ==========================================================
    logic [NCH-1:0] ch_busy; // Any cause on one channel
    logic [NCH-1:0] loop_reg; // Loopback second stage

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        logic [2:0] st0_reg; // First sync stage
        logic [2:0] st1_reg; // Second sync stage
        logic [2:0] st_prev_reg; // For edge finding
        logic loop0_reg;
        logic [tdb_pkg::CNT_W-1:0] sent_reg; // Triggers sent
        logic [tdb_pkg::CNT_W-1:0] tack_reg; // Trigger acks seen
        logic [tdb_pkg::CNT_W-1:0] blk_reg; // Blocks generated
        logic [tdb_pkg::CNT_W-1:0] rack_reg; // Readout acks seen
        logic [tdb_pkg::CNT_W-1:0] owed; // Unacked triggers
        logic [tdb_pkg::CNT_W-1:0] occ; // Front-end buffer level

        // Status bits are asynchronous; two flops, then edges
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                st0_reg <= 3'h0;
                st1_reg <= 3'h0;
                st_prev_reg <= 3'h0;
                loop0_reg <= 1'b0;
                loop_reg[ch] <= 1'b0;
            end else begin
                st0_reg <= fe_status[ch];
                st1_reg <= st0_reg;
                st_prev_reg <= st1_reg;
                loop0_reg <= loop_rx[ch];
                loop_reg[ch] <= loop0_reg;
            end
        end

        // Counters wrap; only their differences matter
        always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
                sent_reg <= '0;
                tack_reg <= '0;
                blk_reg <= '0;
                rack_reg <= '0;
            end else begin
                if (trig_out_reg) begin
                    sent_reg <= sent_reg + 16'h0001;
                    blk_reg <= blk_reg + BLK_PER_TRIG;
                end
                if (st1_reg[1] & ~st_prev_reg[1]) begin
                    tack_reg <= tack_reg + 16'h0001;
                end
                if (st1_reg[0] & ~st_prev_reg[0]) begin
                    rack_reg <= rack_reg + 16'h0001;
                end
            end
        end

        assign owed = sent_reg - tack_reg;
        assign occ = blk_reg - rack_reg;
        // Slack covers acks still on their way back
        assign ch_busy[ch] = st1_reg[2]
            | (owed > ACK_SLACK)
            | (occ >= OCC_HIGH);
    end

    assign loop_tx = loop_reg;

    // ==========================================================
    // Busy merge
    // ==========================================================
    // One OR over every channel and every cause
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
        end else begin
            busy_reg <= |ch_busy;
        end
    end

    assign busy_out = busy_reg;
endmodule

// ===== logic/tdb_pkg.sv
// Purpose: Shared constants and types of the distribution board relay
// Assumes: One system clock; link clock and pins arrive asynchronously
// Notes: Counter widths are fixed; thresholds are defaults for module parameters
package tdb_pkg;
    // ==========
    // Sizes
    // ==========
    localparam int NUM_CH = 8; // Downstream front-end links
    localparam int CMD_W = 4; // Command code bits
    localparam int WORD_W = 16; // Trigger word width
    localparam int CNT_W = 16; // Per-channel counter width
    localparam int ACT_W = 16; // One-hot local actions

    // ==========
    // Command line framing
    // ==========
    localparam logic [2:0] IDLE_ONES = 3'h5; // More than four ones
    localparam logic [2:0] CMD_BITS = 3'h4; // Code bits per frame
    localparam logic [3:0] ENC_LEN = 4'ha; // Start, code, stop, guard
    localparam logic [9:0] ENC_GUARD = 10'h3e0; // Stop plus idle ones
    localparam logic LINE_IDLE = 1'b1; // Idle and stop level
    localparam logic START_BIT = 1'b0; // Frame start level

    // ==========
    // Busy merge defaults
    // ==========
    localparam logic [CNT_W-1:0] ACK_SLACK = 16'h0001; // Acks in flight
    localparam logic [CNT_W-1:0] OCC_HIGH = 16'h0004; // Buffer level limit
    localparam logic [CNT_W-1:0] BLK_PER_TRIG = 16'h0001; // Blocks/trigger

    // ==========
    // Types
    // ==========
    typedef enum logic [1:0] {
        DEC_WAIT_IDLE = 2'b00,
        DEC_ARMED = 2'b01,
        DEC_DATA = 2'b10
    } tdb_dec_state_type;

    // Status returned by one front-end link
    typedef struct packed {
        logic busy;
        logic trig_ack;
        logic ro_ack;
    } tdb_fe_status_type;

    // Decoded command with its strobe
    typedef struct packed {
        logic valid;
        logic [CMD_W-1:0] code;
    } tdb_cmd_type;
endpackage

// ===== testbench/tdb_board_properties.sv
// Purpose: Port timing checks of the distribution board relay
// Assumes: One clk domain, asynchronous active-high reset
// Notes: Latencies are those the relay's designer settled on
module tdb_board_properties #(
    parameter int NCH = tdb_pkg::NUM_CH
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cmd_line_out,
    input wire tdb_pkg::tdb_cmd_type cmd_out,
    input wire logic [tdb_pkg::ACT_W-1:0] local_action,
    input wire logic trig_word_in_ready,
    input wire logic [tdb_pkg::WORD_W-1:0] trig_word_out,
    input wire logic trig_word_out_valid,
    input wire logic trig_word_out_ready,
    input wire logic trig_out,
    input wire tdb_pkg::tdb_fe_status_type [NCH-1:0] fe_status,
    input wire logic [NCH-1:0] loop_rx,
    input wire logic [NCH-1:0] loop_tx,
    input wire logic busy_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // ==========
    // Helper logic
    // ==========
    logic [NCH-1:0] fe_busy; // Busy bit of each front-end link
    // Gather busy bits so one reduction covers every channel
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            fe_busy[i] = fe_status[i].busy;
        end
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    // ==========
    // Command path
    // ==========
    a_action_onehot: assert property (cmd_out.valid |=>
        local_action == (16'h0001 << $past(cmd_out.code))) else $error("action not one-hot");
    a_action_cause: assert property (local_action != 16'h0000 |->
        $past(cmd_out.valid)) else $error("action without command");
    a_valid_single: assert property (cmd_out.valid |=> !cmd_out.valid)
        else $error("command strobe too long");
    a_relay_starts: assert property (cmd_out.valid |-> ##[1:24] !cmd_line_out)
        else $error("relay frame did not start");
    // ==========
    // Trigger, busy and loop path
    // ==========
    a_trig_single: assert property (trig_out |=> !trig_out)
        else $error("trigger pulse too long");
    a_trig_not_busy: assert property (trig_out |-> !$past(busy_out))
        else $error("trigger sent while busy");
    a_busy_from_fe: assert property ((|fe_busy)[*4] |=> busy_out)
        else $error("front-end busy not merged");
    a_loop_delay: assert property ($stable(loop_rx)[*3] |=>
        loop_tx == $past(loop_rx)) else $error("loop pair not returned");
    // ==========
    // Trigger word buffer
    // ==========
    a_full_has_word: assert property (!trig_word_in_ready |-> trig_word_out_valid)
        else $error("refusing while empty");
    a_word_holds: assert property (trig_word_out_valid && !trig_word_out_ready |=>
        trig_word_out_valid && $stable(trig_word_out)) else $error("stalled word lost");
endmodule

// ===== testbench/tdb_supervisor_model.sv
// Purpose: Upstream supervisor sending framed commands
// Assumes: Link clock runs free, as the line is synchronous
// Notes: Bits change on falling link edges, mid-way between samples
module tdb_supervisor_model (
    output logic link_clk,
    output logic cmd_line
);
    timeunit 1ns;
    timeprecision 100ps;
    // Link clock, phase unrelated to clk
    initial begin
        link_clk = 1'b0;
        #13;
        forever #40 link_clk = ~link_clk;
    end
    initial cmd_line = 1'b1; // Line idles high
    // One bit per link period, held until the next bit
    task automatic send_bit(input logic b);
        @(negedge link_clk);
        cmd_line <= b;
    endtask
    // Idle run, start, code LSB first, closing one
    task automatic send_frame(input logic [3:0] code, input int ones);
        repeat (ones) send_bit(1'b1);
        send_bit(1'b0);
        for (int i = 0; i < 4; i++) begin
            send_bit(code[i]);
        end
        send_bit(1'b1);
    endtask
endmodule

// ===== testbench/testbench.sv
// Purpose: Self-checking bench of the distribution board relay
// Assumes: Default thresholds: slack 1, occupancy limit 4
// Notes: Scenario order matters, the ack counters never clear
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, link_clk, cmd_line_in, cmd_line_out;
    tdb_pkg::tdb_cmd_type cmd_out;
    logic [15:0] local_action, trig_word_in, trig_word_out;
    logic trig_word_in_valid, trig_word_in_ready, trig_word_out_valid;
    logic trig_word_out_ready, trig_rear_in, trig_bp_in, trig_sel_bp, trig_out, busy_out;
    tdb_pkg::tdb_fe_status_type [7:0] fe_status;
    logic [7:0] loop_rx, loop_tx;
    int num_errors = 0;
    int total_checks = 0;
    int n_cmd = 0; // Decoded command strobes
    int n_trig = 0; // Forwarded triggers
    int cycles = 0; // Hang guard
    int enc_cnt = 0; // Bit position in relayed frame
    logic [3:0] last_code;
    logic [15:0] last_act;
    logic [4:0] enc_sh; // Stop bit and relayed code
    logic [15:0] popped[$]; // Words leaving the buffer
    tdb_supervisor_model i_sup (.link_clk(link_clk), .cmd_line(cmd_line_in));
    tdb_distribution_board i_dut (.*);
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Monitors sample pre-update register values at the edge
    always @(posedge clk) begin
        cycles++;
        if (cmd_out.valid === 1'b1) begin
            n_cmd++;
            last_code = cmd_out.code;
        end
        if (local_action !== 16'h0000) begin
            last_act = local_action;
        end
        if (trig_out === 1'b1) begin
            n_trig++;
        end
        if (trig_word_out_valid === 1'b1 && trig_word_out_ready === 1'b1) begin
            popped.push_back(trig_word_out);
        end
        if (cycles == 40000) begin
            num_errors++;
            conclude();
        end
    end
    // Relayed frame read mid-bit on falling link edges
    always @(negedge link_clk) begin
        if (enc_cnt == 0 && cmd_line_out === 1'b0) begin
            enc_cnt = 1;
        end else if (enc_cnt > 0) begin
            enc_sh = {cmd_line_out, enc_sh[4:1]};
            enc_cnt = (enc_cnt == 5) ? 0 : enc_cnt + 1;
        end
    end
    // ==========
    // Shared tasks
    // ==========
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Offer a word until the buffer takes it
    task automatic push(input logic [15:0] w);
        trig_word_in = w;
        trig_word_in_valid = 1'b1;
        @(posedge clk iff trig_word_in_ready === 1'b1);
        #1;
        trig_word_in_valid = 1'b0;
        step(1); // Gap between words
    endtask
    task automatic fire(input logic rear, input logic bp);
        trig_rear_in = rear;
        trig_bp_in = bp;
        step(3);
        trig_rear_in = 1'b0;
        trig_bp_in = 1'b0;
        step(10);
    endtask
    // Pulse trigger and readout acks on selected channels
    task automatic ack(input logic [7:0] t, input logic [7:0] r);
        for (int i = 0; i < 8; i++) begin
            fe_status[i].trig_ack = t[i];
            fe_status[i].ro_ack = r[i];
        end
        step(3);
        for (int i = 0; i < 8; i++) begin
            fe_status[i].trig_ack = 1'b0;
            fe_status[i].ro_ack = 1'b0;
        end
        step(6);
    endtask
    // ==========
    // Scenarios
    // ==========
    task automatic s_reset();
        check("line idle", 16'(cmd_line_out), 16'h0001);
        check("busy", 16'(busy_out), 16'h0000);
        check("in ready", 16'(trig_word_in_ready), 16'h0001);
    endtask
    // Every code decoded, acted on and relayed
    task automatic s_commands();
        for (int c = 0; c < 16; c++) begin
            i_sup.send_frame(4'(c), 8);
            step(130);
            check("code", 16'(last_code), 16'(c));
            check("action", last_act, 16'h0001 << c);
            check("relay code", 16'(enc_sh[3:0]), 16'(c));
            check("relay stop", 16'(enc_sh[4]), 16'h0001);
        end
    endtask
    // Four ones after a frame refuse a start, five accept one
    task automatic s_refuse();
        int n;
        n = n_cmd;
        i_sup.send_frame(4'h3, 8);
        i_sup.send_frame(4'h0, 3);
        i_sup.send_frame(4'h5, 4);
        step(130);
        check("frames", 16'(n_cmd - n), 16'h0002);
        check("code", 16'(last_code), 16'h0005);
        check("relay code", 16'(enc_sh[3:0]), 16'h0005);
    endtask
    // Fill until refused, stall, then drain in order
    task automatic s_words();
        trig_word_out_ready = 1'b0;
        push(16'hffff);
        push(16'h0000);
        check("full", 16'(trig_word_in_ready), 16'h0000);
        check("head", trig_word_out, 16'hffff);
        fork
            push(16'ha55a);
            begin
                step(4);
                trig_word_out_ready = 1'b1;
            end
        join
        step(6);
        check("drained", 16'(popped.size()), 16'h0003);
        check("word 0", popped[0], 16'hffff);
        check("word 1", popped[1], 16'h0000);
        check("word 2", popped[2], 16'ha55a);
        check("empty", 16'(trig_word_out_valid), 16'h0000);
    endtask
    task automatic s_busy_or();
        for (int i = 0; i < 8; i++) begin
            fe_status[i].busy = 1'b1;
            step(6);
            check("busy set", 16'(busy_out), 16'h0001);
            fe_status[i].busy = 1'b0;
            step(6);
            check("busy clear", 16'(busy_out), 16'h0000);
        end
    endtask
    task automatic s_trigger();
        int n;
        n = n_trig;
        fire(1'b1, 1'b0);
        fire(1'b0, 1'b1);
        check("rear source", 16'(n_trig - n), 16'h0001);
        trig_sel_bp = 1'b1;
        fire(1'b0, 1'b1);
        fire(1'b1, 1'b0);
        check("bp source", 16'(n_trig - n), 16'h0002);
        ack(8'hff, 8'hff);
        ack(8'hff, 8'hff);
        fire(1'b0, 1'b1);
        check("one missing", 16'(busy_out), 16'h0000);
        fire(1'b0, 1'b1);
        check("two missing", 16'(busy_out), 16'h0001);
        fire(1'b0, 1'b1);
        check("held off", 16'(n_trig - n), 16'h0004);
        ack(8'h7f, 8'h00);
        ack(8'h7f, 8'h00);
        check("one channel", 16'(busy_out), 16'h0001);
        ack(8'h80, 8'h00);
        ack(8'h80, 8'h00);
        check("acked", 16'(busy_out), 16'h0000);
        fire(1'b0, 1'b1);
        ack(8'hff, 8'h00);
        check("level 3", 16'(busy_out), 16'h0000);
        fire(1'b0, 1'b1);
        ack(8'hff, 8'h00);
        check("level 4", 16'(busy_out), 16'h0001);
        ack(8'h00, 8'hff);
        check("read out", 16'(busy_out), 16'h0000);
    endtask
    // Fourth pair returns what it receives
    task automatic s_loop();
        loop_rx = 8'ha5;
        step(4);
        check("loop", 16'(loop_tx), 16'h00a5);
    endtask
    initial begin
        rst = 1'b1;
        fe_status = '0;
        trig_word_in = 16'h0000;
        trig_word_in_valid = 1'b0;
        trig_word_out_ready = 1'b1;
        trig_rear_in = 1'b0;
        trig_bp_in = 1'b0;
        trig_sel_bp = 1'b0;
        loop_rx = 8'h00;
        step(2);
        rst = 1'b0;
        step(1);
        s_reset();
        s_commands();
        s_refuse();
        s_words();
        s_busy_or();
        s_trigger();
        s_loop();
        conclude();
    end
endmodule

bind tdb_distribution_board tdb_board_properties #(.NCH(NCH)) i_props (.clk, .rst,
    .cmd_line_out, .cmd_out, .local_action, .trig_word_in_ready, .trig_word_out,
    .trig_word_out_valid, .trig_word_out_ready, .trig_out, .fe_status, .loop_rx,
    .loop_tx, .busy_out);
